// file: pkg/adcbs_pkg.sv
// adcbs_pkg: shared constants, states and carriers of the hybrid-mode
// background scan sequencer.
// assumes one clock domain; all users import the whole package.
package adcbs_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_GROUPS = 9;
	localparam int NUM_UNITS = 2;
	localparam int NUM_CH = 8;
	localparam int SAMPLE_W = 12;
	localparam int RESULT_W = 16;
	localparam int ACC_W = 15;
	localparam int TOTAL_W = 7;

	// ----------------------------------------------------------------
	// reset values and fixed fields
	// ----------------------------------------------------------------
	localparam logic [NUM_GROUPS-1:0] GROUP_ACTIVE_RST = 9'h000;
	localparam logic [NUM_UNITS-1:0] CONV_ACTIVE_RST = 2'h0;
	localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
	localparam logic [3:0] FRAC_PAD = 4'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_SCAN = 2'h2
	} adcbs_state_e;

	// one word pushed toward a group's fifo data register
	typedef struct packed {
		logic [3:0] group;
		logic [2:0] chan;
		logic [RESULT_W-1:0] data;
	} adcbs_fifo_s;

	// one finished oversample from the converter front end
	typedef struct packed {
		logic [2:0] chan;
		logic [SAMPLE_W-1:0] data;
	} adcbs_sample_s;

endpackage

// file: tb/adcbs_conv_model.sv
// converter front end: answers requests with one sample per pulse
// assumes requests change just after the rising edge
`timescale 1ns/10ps
`default_nettype none
module adcbs_conv_model import adcbs_pkg::*; (
	input wire logic clk,
	input wire logic convReq,
	input wire logic [2:0] convChan,
	input wire logic slow,
	input wire logic [SAMPLE_W-1:0] base,
	output logic convDone,
	output logic [SAMPLE_W-1:0] convData
);
	logic [1:0] waitCnt = 2'h0;
	initial convDone = 1'b0;
	initial convData = 12'h000;
	// ----------------------------------------------------------------
	// sample answer
	// ----------------------------------------------------------------
	// a steady level per channel keeps the filter output exact;
	// data is scrambled outside a pulse so stale values never pass
	always @(posedge clk) begin
		#1;
		waitCnt = waitCnt + 2'h1;
		convDone = convReq && (!slow || waitCnt == 2'h0);
		convData = convDone ? base + {9'h000, convChan} : ~convData;
	end
endmodule
`default_nettype wire

// file: tb/adcbs_scan_seq_sva.sv
// checker: timing relations at the scan sequencer ports
// assumes it is bound onto adcbs_scan_seq, one clock
`timescale 1ns/10ps
`default_nettype none
module adcbs_seq_chk import adcbs_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [NUM_GROUPS-1:0] swTrig,
	input wire logic [NUM_GROUPS-1:0] periphTrig,
	input wire logic [NUM_GROUPS-1:0] groupUnitSel,
	input wire logic [NUM_GROUPS-1:0] groupActiveFlag,
	input wire logic [NUM_UNITS-1:0] converterActiveFlag,
	input wire logic convReq,
	input wire logic convDone,
	input wire logic [2:0] convChan,
	input wire logic [2:0] numChanM1,
	input wire logic forceStop,
	input wire logic fifoEnable,
	input wire logic fifoValid,
	input wire logic scanEndIrqEnable,
	input wire logic scanEndIrq
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic [NUM_GROUPS-1:0] anyTrig = swTrig | periphTrig;
	// lowest requesting group wins when idle
	wire logic [NUM_GROUPS-1:0] lowBit = anyTrig & (~anyTrig + 9'h001);
	wire logic startReq = !convReq && (|anyTrig) && !forceStop;
	chk_start_group: assert property (
		startReq |=> convReq && groupActiveFlag == $past(lowBit))
		else $error("start did not set its group flag");
	chk_start_unit: assert property (
		startReq |=> converterActiveFlag ==
		($past(|(lowBit & groupUnitSel)) ? 2'h2 : 2'h1))
		else $error("start did not set its unit flag");
	chk_chan_rotate: assert property (
		convReq && convDone && !forceStop |=> convChan ==
		(($past(convChan) == $past(numChanM1)) ? 3'h0 : $past(convChan) + 3'h1))
		else $error("channel did not rotate after one sample");
	chk_scan_holds: assert property (
		convReq && !forceStop |=> convReq && $stable(groupActiveFlag))
		else $error("scan ended without a stop");
	chk_stop_clears: assert property (
		forceStop |=> !convReq && groupActiveFlag == 9'h000 &&
		converterActiveFlag == 2'h0)
		else $error("stop left flags or request set");
	chk_irq_gated: assert property (
		scanEndIrq |-> $past(scanEndIrqEnable))
		else $error("scan end pulse while disabled");
	chk_irq_nofifo: assert property (
		convReq && |(anyTrig & groupActiveFlag) && !forceStop && !fifoEnable
		&& scanEndIrqEnable |-> ##2 scanEndIrq)
		else $error("scan end pulse missing after latch");
	chk_fifo_gated: assert property (
		fifoValid |-> $past(fifoEnable))
		else $error("fifo push while fifo disabled");
endmodule
bind adcbs_scan_seq adcbs_seq_chk chk (.clk(clk), .rstn(rstn),
	.swTrig(swTrig), .periphTrig(periphTrig), .groupUnitSel(groupUnitSel),
	.groupActiveFlag(groupActiveFlag), .convReq(convReq),
	.converterActiveFlag(converterActiveFlag), .convDone(convDone),
	.convChan(convChan), .numChanM1(numChanM1), .forceStop(forceStop),
	.fifoEnable(fifoEnable), .fifoValid(fifoValid), .scanEndIrq(scanEndIrq),
	.scanEndIrqEnable(scanEndIrqEnable));
`default_nettype wire

// file: tb/tb_adcbs_scan_seq.sv
// testbench: random scan rounds with latch, fifo, interrupt and stop
// assumes the converter model answers the request line
`timescale 1ns/10ps
`default_nettype none
module tb_adcbs_scan_seq import adcbs_pkg::*;;
	logic clk = 1'b0, rstn = 1'b0, fifoEnable = 1'b0, forceStop = 1'b0;
	logic scanEndIrqEnable = 1'b0, slow = 1'b0;
	logic [NUM_GROUPS-1:0] swTrig = 9'h000, periphTrig = 9'h000;
	logic [NUM_GROUPS-1:0] groupUnitSel = 9'h000, groupActiveFlag;
	logic [2:0] numChanM1 = 3'h0, convChan;
	logic [1:0] tapLog2 = 2'h0, avgLog2 = 2'h0, converterActiveFlag;
	logic [SAMPLE_W-1:0] base = 12'h000, convData;
	logic convDone, convReq, convUnit, fifoValid, scanEndIrq;
	logic [NUM_CH-1:0][RESULT_W-1:0] channelResult;
	logic [NUM_CH-1:0] channelResultValid;
	logic [RESULT_W-1:0] expRes [NUM_CH];
	logic [NUM_CH-1:0] expValid = 8'h00;
	adcbs_fifo_s fifoWord;
	int fails = 0, compares = 0, cyc = 0, nSamp = 0, nIrq, nFifo, g, tot;
	always #20 clk = ~clk;
	adcbs_scan_seq dut (.clk(clk), .rstn(rstn), .swTrig(swTrig),
		.periphTrig(periphTrig), .groupUnitSel(groupUnitSel),
		.numChanM1(numChanM1), .tapLog2(tapLog2), .avgLog2(avgLog2),
		.fifoEnable(fifoEnable), .scanEndIrqEnable(scanEndIrqEnable),
		.forceStop(forceStop), .convDone(convDone), .convData(convData),
		.groupActiveFlag(groupActiveFlag), .convReq(convReq),
		.converterActiveFlag(converterActiveFlag), .convChan(convChan),
		.convUnit(convUnit), .channelResult(channelResult),
		.channelResultValid(channelResultValid), .fifoValid(fifoValid),
		.fifoWord(fifoWord), .scanEndIrq(scanEndIrq));
	adcbs_conv_model conv (.clk(clk), .convReq(convReq), .convChan(convChan),
		.slow(slow), .base(base), .convDone(convDone), .convData(convData));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task end_sim();
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(string what, logic [31:0] e, logic [31:0] s);
		compares++;
		if (e !== s) begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", what, e, s);
		end
	endtask
	function automatic logic [RESULT_W-1:0] res_of(int ch);
		return {base + 12'(ch), FRAC_PAD};
	endfunction
	task trig(int grp);
		@(posedge clk) #1;
		if ($urandom % 2) swTrig[grp] = 1'b1;
		else periphTrig[grp] = 1'b1;
		@(posedge clk) #1;
		swTrig = 9'h000;
		periphTrig = 9'h000;
	endtask
	task latch(bit ready);
		nIrq = 0;
		nFifo = 0;
		trig(g);
		repeat (20) begin
			@(posedge clk) #1;
			nIrq += int'(scanEndIrq);
			if (fifoValid) begin
				nFifo++;
				chk("fifo data", expRes[fifoWord.chan], fifoWord.data);
				chk("fifo group", g, fifoWord.group);
			end
		end
		chk("irq count", scanEndIrqEnable, nIrq);
		if (ready || !fifoEnable)
			chk("fifo count", fifoEnable ? numChanM1 + 1 : 0, nFifo);
		for (int c = 0; c <= numChanM1; c++)
			chk("result", expRes[c], channelResult[c]);
		chk("result valid", expValid, channelResultValid);
	endtask
	always @(posedge clk) begin
		cyc++;
		nSamp += int'(convReq && convDone);
		if (cyc == 60000) begin
			fails++;
			end_sim();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h70bf91e2));
		for (int c = 0; c < NUM_CH; c++) expRes[c] = RESULT_RST;
		repeat (10) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge clk);
		for (int r = 0; r < 6; r++) begin
			g = $urandom % NUM_GROUPS;
			numChanM1 = r < 2 ? (r ? 3'h0 : 3'h7) : 3'($urandom);
			tapLog2 = r < 2 ? (r ? 2'h1 : 2'h2) : 2'($urandom % 3);
			avgLog2 = r < 2 ? (r ? 2'h0 : 2'h1) : 2'($urandom % 3);
			// one sample lands before the first latch; it must not be ready
			if (tapLog2 == 2'h0 && avgLog2 == 2'h0) avgLog2 = 2'h1;
			{fifoEnable, scanEndIrqEnable, slow} = 3'($urandom);
			base = 12'($urandom);
			groupUnitSel = 9'($urandom);
			tot = (int'(numChanM1) + 1) << (int'(tapLog2) + int'(avgLog2));
			trig(g);
			chk("group flag", 32'h1 << g, groupActiveFlag);
			chk("unit flag", groupUnitSel[g] ? 2 : 1, converterActiveFlag);
			chk("unit select", groupUnitSel[g], convUnit);
			// filter was cleared at reset or at the stop, nothing may be ready yet
			latch(1'b0);
			trig((g + 1) % NUM_GROUPS);
			chk("other group", 32'h1 << g, groupActiveFlag);
			nSamp = 0;
			for (int i = 0; i < 9000 && nSamp < tot; i++) @(posedge clk);
			for (int c = 0; c <= numChanM1; c++) expRes[c] = res_of(c);
			for (int c = 0; c <= numChanM1; c++) expValid[c] = 1'b1;
			latch(1'b1);
			nSamp = 0;
			for (int i = 0; i < 9000 && nSamp < tot; i++) @(posedge clk);
			latch(1'b1);
			@(posedge clk) #1 forceStop = 1'b1;
			@(posedge clk) #1 forceStop = 1'b0;
			chk("stop flags", 0, {groupActiveFlag, converterActiveFlag});
			chk("stop request", 0, convReq);
		end
		end_sim();
	end
endmodule
`default_nettype wire

// file: verilog/adcbs_filter.sv
// adcbs_filter: per-channel averaging and tap filter with retained history.
// assumes samples arrive one per valid pulse on the same clock.
`timescale 1ns/10ps
`default_nettype none
module adcbs_filter import adcbs_pkg::*; (
	input wire logic clk,
	input wire logic rstLocalN,
	input wire logic clear,
	input wire logic sampleValid,
	input wire adcbs_sample_s sample,
	input wire logic [1:0] tapLog2,
	input wire logic [1:0] avgLog2,
	output logic [NUM_CH-1:0][RESULT_W-1:0] filtOut,
	output logic [NUM_CH-1:0] filtReady
);

	// ----------------------------------------------------------------
	// selected channel arithmetic
	// ----------------------------------------------------------------
	logic [ACC_W-1:0] acc_ff [NUM_CH];
	logic [2:0] sub_ff [NUM_CH];
	logic [TOTAL_W-1:0] total_ff [NUM_CH];
	logic [RESULT_W-1:0] flt_ff [NUM_CH];
	logic [NUM_CH-1:0] ready_ff;

	wire [2:0] ch = sample.chan;
	wire [ACC_W-1:0] accSum = acc_ff[ch] + {3'h0, sample.data};
	wire [2:0] subMax = 3'((4'h1 << avgLog2) - 4'h1);
	wire groupEnd = (sub_ff[ch] == subMax);
	wire [ACC_W-1:0] avgFull = accSum >> avgLog2;
	wire [RESULT_W-1:0] avg16 = {avgFull[SAMPLE_W-1:0], FRAC_PAD};
	wire [RESULT_W-1:0] oldFlt = flt_ff[ch];
	// a first pass seeds the filter so the tap settles from real data
	wire [RESULT_W-1:0] nxt_flt = (total_ff[ch] == 7'h00) ? avg16 :
		oldFlt - (oldFlt >> tapLog2) + (avg16 >> tapLog2);
	// initial delay length
	// counted in finished averaging groups, so the tap count alone sets it
	wire [TOTAL_W-1:0] initLen = 7'h01 << tapLog2;
	wire [TOTAL_W-1:0] totalInc = total_ff[ch] + 7'h01;
	wire [TOTAL_W-1:0] nxt_total = (totalInc >= initLen) ? initLen :
		totalInc;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstLocalN) begin
		if (!rstLocalN) begin
			for (int i = 0; i < NUM_CH; i++) begin
				acc_ff[i] <= '0;
				sub_ff[i] <= 3'h0;
				total_ff[i] <= 7'h00;
				flt_ff[i] <= RESULT_RST;
			end
			ready_ff <= 8'h00;
		end else if (clear) begin
			for (int i = 0; i < NUM_CH; i++) begin
				acc_ff[i] <= '0;
				sub_ff[i] <= 3'h0;
				total_ff[i] <= 7'h00;
				flt_ff[i] <= RESULT_RST;
			end
			ready_ff <= 8'h00;
		end else if (sampleValid) begin
			acc_ff[ch] <= groupEnd ? '0 : accSum;
			sub_ff[ch] <= groupEnd ? 3'h0 : sub_ff[ch] + 3'h1;
			if (groupEnd) begin
				flt_ff[ch] <= nxt_flt;
				total_ff[ch] <= nxt_total;
			end
			if (groupEnd && (totalInc >= initLen)) begin
				ready_ff[ch] <= 1'b1;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			filtOut[i] = flt_ff[i];
		end
	end
	assign filtReady = ready_ff;

endmodule
`default_nettype wire

// file: verilog/adcbs_scan_seq.sv
// adcbs_scan_seq: hybrid-mode background continuous scan sequencer.
// assumes triggers, converter handshake and stop come from logic on clk.
// Notes on behaviour
// - trigger starts its assigned scan group
// - group active flag set on start
// - converting unit active flag set too
// - next channel after every single oversample
// - first result after filter_tap_count times averages
// - filter history kept and updated later
// - later results every averaging group
// - fifo enabled pushes latched results per group
// - scan end interrupt only when enabled
// - rounds repeat until stop, relatch on each active group trigger when no push or interrupt is pending
`timescale 1ns/10ps
`default_nettype none
module adcbs_scan_seq import adcbs_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [NUM_GROUPS-1:0] swTrig,
	input wire logic [NUM_GROUPS-1:0] periphTrig,
	input wire logic [NUM_GROUPS-1:0] groupUnitSel,
	input wire logic [2:0] numChanM1,
	input wire logic [1:0] tapLog2,
	input wire logic [1:0] avgLog2,
	input wire logic fifoEnable,
	input wire logic scanEndIrqEnable,
	input wire logic forceStop,
	input wire logic convDone,
	input wire logic [SAMPLE_W-1:0] convData,
	output logic [NUM_GROUPS-1:0] groupActiveFlag,
	output logic [NUM_UNITS-1:0] converterActiveFlag,
	output logic convReq,
	output logic [2:0] convChan,
	output logic convUnit,
	output logic [NUM_CH-1:0][RESULT_W-1:0] channelResult,
	output logic [NUM_CH-1:0] channelResultValid,
	output logic fifoValid,
	output adcbs_fifo_s fifoWord,
	output logic scanEndIrq
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rstSync_ff;
	wire rstLocalN = rstSync_ff[1];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstSync_ff <= 2'h0;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// trigger decode
	// ----------------------------------------------------------------
	function automatic logic [3:0] lowestGroup(
		input logic [NUM_GROUPS-1:0] req
	);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = NUM_GROUPS - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	adcbs_state_e state_ff;
	adcbs_state_e nxt_state;
	logic [3:0] activeGroup_ff;
	logic [NUM_GROUPS-1:0] groupActive_ff;
	logic [NUM_UNITS-1:0] convActive_ff;
	logic convReq_ff;
	logic [2:0] convChan_ff;
	logic convUnit_ff;
	logic [NUM_CH-1:0][RESULT_W-1:0] result_ff;
	logic [NUM_CH-1:0] resultValid_ff;
	logic pushBusy_ff;
	logic [2:0] pushIdx_ff;
	logic fifoValid_ff;
	adcbs_fifo_s fifoWord_ff;
	logic irq_ff;
	logic irqPend_ff;

	wire [NUM_GROUPS-1:0] anyTrig = swTrig | periphTrig;
	wire [3:0] startGroup = lowestGroup(anyTrig);
	wire startUnit = groupUnitSel[startGroup];
	wire isIdle = (state_ff == ST_IDLE);
	wire isScan = (state_ff == ST_SCAN);
	wire startScan = isIdle && (anyTrig != 9'h000) && !forceStop;
	// latch trigger for the active group
	wire latchTrig = isScan && anyTrig[activeGroup_ff] && !forceStop &&
		!pushBusy_ff && !irqPend_ff;
	wire sampleTaken = isScan && convReq_ff && convDone;
	wire [2:0] nextChan = (convChan_ff == numChanM1) ? 3'h0 :
		convChan_ff + 3'h1;
	wire pushLast = (pushIdx_ff == numChanM1);

	wire [NUM_CH-1:0][RESULT_W-1:0] filtOut;
	wire [NUM_CH-1:0] filtReady;
	wire adcbs_sample_s sampleIn = '{chan: convChan_ff, data: convData};

	adcbs_filter uFilter (
		.clk(clk),
		.rstLocalN(rstLocalN),
		.clear(forceStop),
		.sampleValid(sampleTaken),
		.sample(sampleIn),
		.tapLog2(tapLog2),
		.avgLog2(avgLog2),
		.filtOut(filtOut),
		.filtReady(filtReady)
	);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (startScan) begin
					nxt_state = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (forceStop) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstLocalN) begin
		if (!rstLocalN) begin
			state_ff <= ST_IDLE;
			activeGroup_ff <= 4'h0;
			groupActive_ff <= GROUP_ACTIVE_RST;
			convActive_ff <= CONV_ACTIVE_RST;
			convUnit_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (forceStop) begin
				groupActive_ff <= GROUP_ACTIVE_RST;
				convActive_ff <= CONV_ACTIVE_RST;
			end else if (startScan) begin
				activeGroup_ff <= startGroup;
				convUnit_ff <= startUnit;
				groupActive_ff[startGroup] <= 1'b1;
				convActive_ff[startUnit] <= 1'b1;
			end
		end
	end

	// converter request stands until a stop; each front end answer only advances the channel
	always_ff @(posedge clk or negedge rstLocalN) begin
		if (!rstLocalN) begin
			convReq_ff <= 1'b0;
			convChan_ff <= 3'h0;
		end else if (forceStop) begin
			convReq_ff <= 1'b0;
			convChan_ff <= 3'h0;
		end else if (startScan) begin
			convReq_ff <= 1'b1;
			convChan_ff <= 3'h0;
		end else if (sampleTaken) begin
			convChan_ff <= nextChan;
		end
	end

	// ----------------------------------------------------------------
	// result latching, fifo push, interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstLocalN) begin
		if (!rstLocalN) begin
			result_ff <= '0;
			resultValid_ff <= 8'h00;
		end else if (latchTrig) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (filtReady[i]) begin
					result_ff[i] <= filtOut[i];
					resultValid_ff[i] <= 1'b1;
				end
			end
		end
	end

	// one word per cycle keeps the push narrow; triggers meanwhile are ignored
	always_ff @(posedge clk or negedge rstLocalN) begin
		if (!rstLocalN) begin
			pushBusy_ff <= 1'b0;
			pushIdx_ff <= 3'h0;
			fifoValid_ff <= 1'b0;
			fifoWord_ff <= '0;
			irqPend_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			fifoValid_ff <= 1'b0;
			irq_ff <= 1'b0;
			if (forceStop) begin
				pushBusy_ff <= 1'b0;
				irqPend_ff <= 1'b0;
			end else if (latchTrig) begin
				pushBusy_ff <= fifoEnable;
				pushIdx_ff <= 3'h0;
				irqPend_ff <= 1'b1;
			end else if (pushBusy_ff) begin
				if (resultValid_ff[pushIdx_ff]) begin
					fifoValid_ff <= 1'b1;
				end
				fifoWord_ff <= '{group: activeGroup_ff,
					chan: pushIdx_ff, data: result_ff[pushIdx_ff]};
				pushIdx_ff <= pushIdx_ff + 3'h1;
				if (pushLast) begin
					pushBusy_ff <= 1'b0;
				end
			end else if (irqPend_ff) begin
				irqPend_ff <= 1'b0;
				irq_ff <= scanEndIrqEnable;
			end
		end
	end

	assign groupActiveFlag = groupActive_ff;
	assign converterActiveFlag = convActive_ff;
	assign convReq = convReq_ff;
	assign convChan = convChan_ff;
	assign convUnit = convUnit_ff;
	assign channelResult = result_ff;
	assign channelResultValid = resultValid_ff;
	assign fifoValid = fifoValid_ff;
	assign fifoWord = fifoWord_ff;
	assign scanEndIrq = irq_ff;

endmodule
`default_nettype wire
